/* File: include/serial_map.vh */
// register map, field positions and timing constants of the serial ports
`ifndef SERIAL_MAP_VH
`define SERIAL_MAP_VH

// register offsets inside an eight-location port window
`define WINDOW_BITS 3
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_IIR 3'h2
`define OFS_LCR 3'h3
`define OFS_MCR 3'h4
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6
`define OFS_SCR 3'h7

// character_format fields
`define LCR_STOP 2
`define LCR_PEN 3
`define LCR_EVEN 4
`define LCR_BREAK 6
`define LCR_DIV_SEL 7

// line_output_control fields
`define MCR_RTS 1
`define MCR_GATE 3

// interrupt enable field
`define IER_RX 0

// interrupt_source values
`define IIR_RX 8'h04
`define IIR_NONE 8'h01

// reset values
`define RST_BYTE 8'h00
`define RST_DIV 16'h000C
`define RST_DIV_LO 8'h0C
`define RST_DIV_HI 8'h00

// clocks
`define SYS_HZ 40000000
`define SLOW_REF_HZ 1843200
`define FAST_REF_HZ 7372800
`define NCO_BITS 24
`define SAMPLE_PHASE 4'h7
`define LAST_PHASE 4'hF

`endif

/* File: core/dual_serial_port_uart.v */
// two-port uart behind a host i/o window, with line driver control
`timescale 1ns/1ps
`include "serial_map.vh"

module uart_channel #(
  parameter GATE_LEVEL = 1'b1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire ref_tick,
  // register access
  input wire sel,
  input wire rd,
  input wire wr,
  input wire [2:0] offs,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  // jumper
  input wire auto_mode,
  // line side
  input wire rx_pin,
  output reg tx_pin,
  output wire rts,
  output reg drv_en,
  output reg irq
);

  // mask of valid data bits for a given length code
  function [7:0] len_mask;
    input [1:0] w;
    begin
      len_mask = 8'hFF >> (2'h3 - w);
    end
  endfunction

  // frame length in bits: start, data, parity, stop
  function [3:0] frame_bits;
    input [7:0] lcr;
    input two_stop;
    begin
      frame_bits = 4'h7 + {2'h0, lcr[1:0]} + {3'h0, lcr[`LCR_PEN]}
        + {3'h0, two_stop};
    end
  endfunction

  // whole frame, lsb first, padded with stop level
  function [11:0] tx_frame;
    input [7:0] d;
    input [7:0] lcr;
    integer i;
    reg [3:0] n;
    begin
      n = 4'h5 + {2'h0, lcr[1:0]};
      tx_frame = 12'hFFF;
      tx_frame[0] = 1'b0;
      for (i = 0; i < 8; i = i + 1)
        if (i < n)
          tx_frame[i + 1] = d[i];
      if (lcr[`LCR_PEN])
        tx_frame[n + 4'h1] = ^(d & len_mask(lcr[1:0])) ^ ~lcr[`LCR_EVEN];
    end
  endfunction

  reg [7:0] dll_reg;
  reg [7:0] dlm_reg;
  reg [7:0] lcr_reg;
  reg [7:0] scr_reg;
  reg [3:0] ier_reg;
  reg [4:0] mcr_reg;
  wire divisor_latch_select;
  wire wr_hit;
  wire rd_hit;
  wire rd_data;
  wire rd_lsr;
  wire [3:0] data_len;

  assign divisor_latch_select = lcr_reg[`LCR_DIV_SEL];
  assign wr_hit = sel & wr;
  assign rd_hit = sel & rd;
  assign rd_data = rd_hit & ~divisor_latch_select
    & (offs == `OFS_DATA);
  assign rd_lsr = rd_hit & (offs == `OFS_LSR);
  assign data_len = 4'h5 + {2'h0, lcr_reg[1:0]};

  // register writes
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dll_reg <= `RST_DIV_LO;
      dlm_reg <= `RST_DIV_HI;
      lcr_reg <= `RST_BYTE;
      scr_reg <= `RST_BYTE;
      ier_reg <= 4'h0;
      mcr_reg <= 5'h00;
    end
    else if (wr_hit)
    begin
      case (offs)
        `OFS_DATA:
          if (divisor_latch_select)
            dll_reg <= wdata;
        `OFS_IER:
          if (divisor_latch_select)
            dlm_reg <= wdata;
          else
            ier_reg <= wdata[3:0];
        `OFS_LCR: lcr_reg <= wdata;
        `OFS_MCR: mcr_reg <= wdata[4:0];
        `OFS_SCR: scr_reg <= wdata;
        default: scr_reg <= scr_reg;
      endcase
    end
  end

  // baud divider: one tick per sixteenth of a bit
  reg [15:0] div_cnt_reg;
  reg tick_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_reg <= 16'h0001;
      tick_reg <= 1'b0;
    end
    else if (ref_tick)
    begin
      if (div_cnt_reg <= 16'h0001)
      begin
        div_cnt_reg <= {dlm_reg, dll_reg};
        tick_reg <= 1'b1;
      end
      else
      begin
        div_cnt_reg <= div_cnt_reg - 16'h0001;
        tick_reg <= 1'b0;
      end
    end
    else
      tick_reg <= 1'b0;
  end

  // two-entry transmit buffer; a full buffer refuses further writes
  reg [7:0] buf_mem [0:1];
  reg wp_reg;
  reg rp_reg;
  reg [1:0] cnt_reg;
  reg [11:0] tx_sh_reg;
  reg [3:0] tx_left_reg;
  reg [3:0] tx_ph_reg;
  wire fill_valid;
  wire fill_ready;
  wire drain_valid;
  wire drain_ready;
  wire push;
  wire pop;

  assign fill_valid = wr_hit & ~divisor_latch_select
    & (offs == `OFS_DATA);
  assign fill_ready = (cnt_reg != 2'h2);
  assign drain_valid = (cnt_reg != 2'h0);
  // shifter waits while the divisor is selected
  assign drain_ready = (tx_left_reg == 4'h0) & ~divisor_latch_select;
  assign push = fill_valid & fill_ready;
  assign pop = drain_valid & drain_ready;

  always @(posedge clk)
  begin
    if (push)
      buf_mem[wp_reg] <= wdata;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (push)
        wp_reg <= ~wp_reg;
      if (pop)
        rp_reg <= ~rp_reg;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 2'h1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 2'h1;
    end
  end

  // transmit shifter
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sh_reg <= 12'hFFF;
      tx_left_reg <= 4'h0;
      tx_ph_reg <= 4'h0;
    end
    else if (pop)
    begin
      tx_sh_reg <= tx_frame(buf_mem[rp_reg], lcr_reg);
      tx_left_reg <= frame_bits(lcr_reg, lcr_reg[`LCR_STOP]);
      tx_ph_reg <= 4'h0;
    end
    else if (tick_reg && tx_left_reg != 4'h0)
    begin
      tx_ph_reg <= tx_ph_reg + 4'h1;
      if (tx_ph_reg == `LAST_PHASE)
      begin
        tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
      end
    end
  end

  // jumper is a pin; two flops before the driver logic reads it
  reg [1:0] auto_sync_reg;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      auto_sync_reg <= 2'h0;
    else
      auto_sync_reg <= {auto_sync_reg[0], auto_mode};
  end

  // break holds the line low whatever the shifter does
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_pin <= 1'b1;
      drv_en <= 1'b0;
    end
    else
    begin
      tx_pin <= ~lcr_reg[`LCR_BREAK]
        & ((tx_left_reg == 4'h0) | tx_sh_reg[0]);
      if (auto_sync_reg[1])
        drv_en <= drain_valid | (tx_left_reg != 4'h0);
      else
        drv_en <= mcr_reg[`MCR_RTS];
    end
  end

  // local pin only; never sent on the line, clear-to-send not sampled
  assign rts = mcr_reg[`MCR_RTS];

  // receiver
  reg [1:0] rx_sync_reg;
  reg rx_busy_reg;
  reg [3:0] rx_ph_reg;
  reg [3:0] rx_idx_reg;
  reg [11:0] rx_sh_reg;
  reg [7:0] rbr_reg;
  reg dr_reg;
  reg oe_reg;
  reg pe_reg;
  reg fe_reg;
  wire rx_line;
  wire rx_sample;
  wire rx_done;
  wire [7:0] rx_data;
  wire rx_perr;

  assign rx_line = rx_sync_reg[1];
  assign rx_sample = tick_reg & rx_busy_reg & (rx_ph_reg == `SAMPLE_PHASE);
  assign rx_done = rx_sample & (rx_idx_reg != 4'h0)
    & (rx_idx_reg == frame_bits(lcr_reg, 1'b0) - 4'h1);
  assign rx_data = rx_sh_reg[8:1] & len_mask(lcr_reg[1:0]);
  assign rx_perr = lcr_reg[`LCR_PEN]
    & (^rx_data ^ rx_sh_reg[data_len + 4'h1] ^ ~lcr_reg[`LCR_EVEN]);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_sync_reg <= 2'h3;
    else
      rx_sync_reg <= {rx_sync_reg[0], rx_pin};
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_busy_reg <= 1'b0;
      rx_ph_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_sh_reg <= 12'hFFF;
    end
    else if (!rx_busy_reg)
    begin
      if (tick_reg & ~rx_line & ~divisor_latch_select)
      begin
        rx_busy_reg <= 1'b1;
        rx_ph_reg <= 4'h0;
        rx_idx_reg <= 4'h0;
      end
    end
    else if (tick_reg)
    begin
      rx_ph_reg <= rx_ph_reg + 4'h1;
      if (rx_sample)
      begin
        rx_sh_reg[rx_idx_reg] <= rx_line;
        rx_idx_reg <= rx_idx_reg + 4'h1;
        // a start bit gone high again is a glitch, not a character
        if ((rx_idx_reg == 4'h0 && rx_line) || rx_done)
          rx_busy_reg <= 1'b0;
      end
    end
  end

  // status flags: a new character wins over a clearing read
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rbr_reg <= `RST_BYTE;
      dr_reg <= 1'b0;
      oe_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
    end
    else
    begin
      if (rx_done)
        rbr_reg <= rx_data;
      if (rx_done)
        dr_reg <= 1'b1;
      else if (rd_data)
        dr_reg <= 1'b0;
      if (rx_done & dr_reg & ~rd_data)
        oe_reg <= 1'b1;
      else if (rd_lsr)
        oe_reg <= 1'b0;
      if (rx_done & rx_perr)
        pe_reg <= 1'b1;
      else if (rd_lsr)
        pe_reg <= 1'b0;
      if (rx_done & ~rx_line)
        fe_reg <= 1'b1;
      else if (rd_lsr)
        fe_reg <= 1'b0;
    end
  end

  // interrupt: bit 2 of line_output_control is left without effect
  wire rx_pending;
  assign rx_pending = dr_reg & ier_reg[`IER_RX];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= rx_pending & (mcr_reg[`MCR_GATE] == GATE_LEVEL);
  end

  // read mux
  always @*
  begin
    case (offs)
      `OFS_DATA: rdata = divisor_latch_select ? dll_reg : rbr_reg;
      `OFS_IER: rdata = divisor_latch_select ? dlm_reg
        : {4'h0, ier_reg};
      `OFS_IIR: rdata = rx_pending ? `IIR_RX : `IIR_NONE;
      `OFS_LCR: rdata = lcr_reg;
      `OFS_MCR: rdata = {3'h0, mcr_reg};
      `OFS_LSR: rdata = {1'b0, (cnt_reg == 2'h0) & (tx_left_reg == 4'h0),
        fill_ready, 1'b0, fe_reg, pe_reg, oe_reg, dr_reg};
      `OFS_SCR: rdata = scr_reg;
      default: rdata = 8'h00;
    endcase
  end

endmodule

module dual_serial_port_uart #(
  parameter [15:0] VENDOR_ID = 16'h1234, // arbitrary value
  parameter [15:0] DEVICE_ID = 16'h5678, // arbitrary value
  parameter GATE_LEVEL = 1'b1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // host i/o port
  input wire [15:0] io_addr,
  input wire io_rd,
  input wire io_wr,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  // configuration space
  input wire [15:0] first_serial_port_base,
  input wire [15:0] second_serial_port_base,
  output wire [15:0] vendor_id,
  output wire [15:0] device_id,
  // jumpers
  input wire fast_clock_select,
  input wire first_auto_mode,
  input wire second_auto_mode,
  // first serial port
  input wire first_rx,
  output wire first_tx,
  output wire first_rts,
  output wire first_drv_en,
  output wire first_irq,
  // second serial port
  input wire second_rx,
  output wire second_tx,
  output wire second_rts,
  output wire second_drv_en,
  output wire second_irq
);

  localparam [63:0] NCO_ONE = 64'h0000_0000_0000_0001 << `NCO_BITS;
  localparam [63:0] INC_SLOW = (`SLOW_REF_HZ * NCO_ONE) / `SYS_HZ;
  localparam [63:0] INC_FAST = (`FAST_REF_HZ * NCO_ONE) / `SYS_HZ;

  assign vendor_id = VENDOR_ID;
  assign device_id = DEVICE_ID;

  // jumper may move at any time; synchronise before use
  reg [1:0] fast_sync_reg;
  reg [24:0] nco_reg;
  wire [23:0] nco_inc;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fast_sync_reg <= 2'h0;
    else
      fast_sync_reg <= {fast_sync_reg[0], fast_clock_select};
  end

  // reference clock as a fractional enable: jitter of one system period
  assign nco_inc = fast_sync_reg[1] ? INC_FAST[23:0] : INC_SLOW[23:0];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      nco_reg <= 25'h000_0000;
    else
      nco_reg <= {1'b0, nco_reg[23:0]} + {1'b0, nco_inc};
  end

  // window decode; the first port wins if both bases overlap
  wire first_hit;
  wire second_hit;
  wire [7:0] first_rdata;
  wire [7:0] second_rdata;

  assign first_hit = io_addr[15:`WINDOW_BITS]
    == first_serial_port_base[15:`WINDOW_BITS];
  assign second_hit = ~first_hit & (io_addr[15:`WINDOW_BITS]
    == second_serial_port_base[15:`WINDOW_BITS]);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      io_rdata <= 8'h00;
    else if (io_rd)
      io_rdata <= first_hit ? first_rdata
        : (second_hit ? second_rdata : 8'hFF);
  end

  uart_channel #(.GATE_LEVEL(GATE_LEVEL)) first_port (
    .clk(clk),
    .rst_n(rst_n),
    .ref_tick(nco_reg[24]),
    .sel(first_hit),
    .rd(io_rd),
    .wr(io_wr),
    .offs(io_addr[2:0]),
    .wdata(io_wdata),
    .rdata(first_rdata),
    .auto_mode(first_auto_mode),
    .rx_pin(first_rx),
    .tx_pin(first_tx),
    .rts(first_rts),
    .drv_en(first_drv_en),
    .irq(first_irq)
  );

  uart_channel #(.GATE_LEVEL(GATE_LEVEL)) second_port (
    .clk(clk),
    .rst_n(rst_n),
    .ref_tick(nco_reg[24]),
    .sel(second_hit),
    .rd(io_rd),
    .wr(io_wr),
    .offs(io_addr[2:0]),
    .wdata(io_wdata),
    .rdata(second_rdata),
    .auto_mode(second_auto_mode),
    .rx_pin(second_rx),
    .tx_pin(second_tx),
    .rts(second_rts),
    .drv_en(second_drv_en),
    .irq(second_irq)
  );

endmodule

/* File: testbench/serial_asserts.sv */
// checker for the host window and line outputs
`timescale 1ns/1ps
module serial_asserts #(
  parameter [15:0] VENDOR_ID = 16'h1234,
  parameter [15:0] DEVICE_ID = 16'h5678,
  parameter GATE_LEVEL = 1'b1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // host side
  input wire [15:0] io_addr,
  input wire io_rd,
  input wire io_wr,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire [15:0] first_serial_port_base,
  input wire [15:0] second_serial_port_base,
  input wire [15:0] vendor_id,
  input wire [15:0] device_id,
  // line side
  input wire first_auto_mode,
  input wire second_auto_mode,
  input wire first_tx,
  input wire first_rts,
  input wire first_drv_en,
  input wire first_irq,
  input wire second_rts,
  input wire second_drv_en
);
  reg [7:0] fmt_reg;
  reg [7:0] ctl_reg;
  wire hit_a = io_addr[15:3] == first_serial_port_base[15:3];
  wire hit_b = io_addr[15:3] == second_serial_port_base[15:3];
  wire wr_a = io_wr && hit_a;
  // shadow of the first port's format and output control
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fmt_reg <= 8'h00;
      ctl_reg <= 8'h00;
    end
    else if (wr_a && io_addr[2:0] == 3'h3)
      fmt_reg <= io_wdata;
    else if (wr_a && io_addr[2:0] == 3'h4)
      ctl_reg <= io_wdata;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // auto mode: driver low means buffer and shifter idle
  sequence s_load;
    wr_a && io_addr[2:0] == 3'h0 && !fmt_reg[7] && first_auto_mode
      && !first_drv_en;
  endsequence
  sequence s_rx_read;
    io_rd && hit_a && io_addr[2:0] == 3'h0 && !fmt_reg[7];
  endsequence
  a_id_codes: assert property (
    vendor_id == VENDOR_ID && device_id == DEVICE_ID)
    else $error("identification codes wrong");
  a_unmapped_read: assert property (
    io_rd && !hit_a && !hit_b |=> io_rdata == 8'hFF)
    else $error("unmapped read not all ones");
  a_tx_start: assert property (
    s_load |-> ##[2:3] !first_tx)
    else $error("no start bit after data write");
  a_drive_on: assert property (
    s_load |-> ##[1:2] first_drv_en)
    else $error("driver not enabled for pending data");
  a_auto_drive: assert property (
    first_auto_mode && !first_tx && !fmt_reg[6] && !$past(fmt_reg[6])
      |-> first_drv_en)
    else $error("line driven low with driver off");
  a_no_start: assert property (
    fmt_reg[7] && !fmt_reg[6] && first_auto_mode && first_tx
      && !first_drv_en |=> first_tx)
    else $error("transmit started with divisor selected");
  a_rts_bit: assert property (
    first_rts == ctl_reg[1])
    else $error("request-to-send differs from control bit");
  a_manual_drive: assert property (
    !second_auto_mode |=> second_drv_en == $past(second_rts))
    else $error("manual driver does not follow request-to-send");
  a_irq_gate: assert property (
    $rose(first_irq) |-> $past(ctl_reg[3]) == GATE_LEVEL)
    else $error("interrupt raised with gate closed");
  a_irq_clear: assert property (
    s_rx_read |-> ##[1:3] !first_irq)
    else $error("interrupt kept after data read");
endmodule

/* File: testbench/serial_station.sv */
// remote serial station sending and collecting characters
`timescale 1ns/1ps
module serial_station #(
  parameter real BIT_NS = 2170.14
) (
  output reg line_out,
  input wire line_in
);
  reg [7:0] last;
  integer count;
  integer i;
  integer j;
  initial
  begin
    line_out = 1'b1;
    count = 0;
    last = 8'h00;
  end
  // start, eight data lsb first, one stop
  task send(input [7:0] v);
    begin
      line_out = 1'b0;
      #(BIT_NS);
      for (i = 0; i < 8; i = i + 1)
      begin
        line_out = v[i];
        #(BIT_NS);
      end
      line_out = 1'b1;
      #(BIT_NS);
    end
  endtask
  // samples mid-bit so small rate error is tolerated
  always
  begin
    @(negedge line_in);
    #(BIT_NS * 1.5);
    for (j = 0; j < 8; j = j + 1)
    begin
      last[j] = line_in;
      #(BIT_NS);
    end
    count = count + 1;
  end
endmodule

/* File: testbench/dual_serial_port_uart_tb.sv */
// self-checking bench for the two-port serial block
`timescale 1ns/1ps
module dual_serial_port_uart_tb;
  localparam [15:0] PA = 16'h0300;
  localparam [15:0] PB = 16'hFFF8;
  reg clk;
  reg rst_n;
  reg [15:0] io_addr;
  reg io_rd;
  reg io_wr;
  reg [7:0] io_wdata;
  reg [7:0] d;
  wire [7:0] io_rdata;
  wire [15:0] vendor_id;
  wire [15:0] device_id;
  wire first_rx, first_tx, first_rts, first_drv_en, first_irq;
  wire second_tx, second_rts, second_drv_en, second_irq;
  integer bad_count;
  integer samples_checked;
  integer n;
  dual_serial_port_uart dut (
    .clk(clk), .rst_n(rst_n),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata),
    .first_serial_port_base(PA), .second_serial_port_base(PB),
    .vendor_id(vendor_id), .device_id(device_id),
    .fast_clock_select(1'b1),
    .first_auto_mode(1'b1), .second_auto_mode(1'b0),
    .first_rx(first_rx), .first_tx(first_tx), .first_rts(first_rts),
    .first_drv_en(first_drv_en), .first_irq(first_irq),
    .second_rx(first_tx), .second_tx(second_tx),
    .second_rts(second_rts), .second_drv_en(second_drv_en),
    .second_irq(second_irq)
  );
  // divisor 1 on the fast reference
  serial_station #(.BIT_NS(2170.14)) st (
    .line_out(first_rx), .line_in(first_tx));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input [63:0] s, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("unexpected %0s exp %h seen %h", s, exp, seen);
      end
    end
  endtask
  task acc(input w, input [15:0] b, input [2:0] o, input [7:0] v);
    begin
      @(posedge clk);
      io_addr <= {b[15:3], o};
      io_wdata <= v;
      io_wr <= w;
      io_rd <= !w;
      @(posedge clk);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      @(negedge clk);
      d = io_rdata;
    end
  endtask
  task rc(input [15:0] b, input [2:0] o, input [7:0] e, input [63:0] s);
    begin
      acc(1'b0, b, o, 8'h00);
      chk(s, {8'h00, d}, {8'h00, e});
    end
  endtask
  task t_reset;
    begin
      rc(PA, 3'h3, 8'h00, "format");
      rc(PA, 3'h5, 8'h60, "status");
      rc(PA, 3'h2, 8'h01, "source");
      rc(16'h0308, 3'h0, 8'hFF, "unmapped");
      rc(PB, 3'h5, 8'h60, "status b");
      chk("vendor", vendor_id, 16'h1234);
      chk("device", device_id, 16'h5678);
    end
  endtask
  task t_divisor;
    begin
      acc(1'b1, PA, 3'h3, 8'h80);
      acc(1'b1, PA, 3'h0, 8'h01);
      acc(1'b1, PA, 3'h1, 8'h00);
      rc(PA, 3'h0, 8'h01, "div lo");
      rc(PA, 3'h1, 8'h00, "div hi");
      acc(1'b1, PA, 3'h3, 8'h03);
      acc(1'b1, PA, 3'h1, 8'h01);
      rc(PA, 3'h1, 8'h01, "enable");
      acc(1'b0, PA, 3'h0, 8'h00);
      acc(1'b0, PA, 3'h0, 8'h00);
    end
  endtask
  task t_manual;
    begin
      acc(1'b1, PB, 3'h4, 8'h02);
      chk("rts", {15'h0000, second_rts}, 16'h0001);
      @(negedge clk);
      chk("drv", {15'h0000, second_drv_en}, 16'h0001);
      acc(1'b1, PB, 3'h4, 8'h00);
      @(negedge clk);
      chk("drv off", {15'h0000, second_drv_en}, 16'h0000);
      chk("tx b", {15'h0000, second_tx}, 16'h0001);
      chk("irq b", {15'h0000, second_irq}, 16'h0000);
    end
  endtask
  task t_tx;
    begin
      acc(1'b1, PA, 3'h0, 8'hA5);
      n = 0;
      while (st.count == 0 && n < 3000)
      begin
        @(posedge clk);
        n = n + 1;
      end
      chk("sent", {8'h00, st.last}, 16'h00A5);
      repeat (100) @(posedge clk);
      rc(PA, 3'h5, 8'h60, "empty");
    end
  endtask
  task t_rx;
    begin
      acc(1'b1, PA, 3'h4, 8'h08);
      st.send(8'h3C);
      n = 0;
      while (first_irq !== 1'b1 && n < 3000)
      begin
        @(posedge clk);
        n = n + 1;
      end
      chk("irq", {15'h0000, first_irq}, 16'h0001);
      rc(PA, 3'h2, 8'h04, "source");
      rc(PA, 3'h5, 8'h61, "ready");
      rc(PA, 3'h0, 8'h3C, "rx data");
      repeat (3) @(posedge clk);
      chk("irq off", {15'h0000, first_irq}, 16'h0000);
      rc(PA, 3'h5, 8'h60, "drained");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    #(25 * 20000);
    bad_count = bad_count + 1;
    end_sim;
  end
  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    io_addr = 16'h0000;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_divisor;
    t_manual;
    t_tx;
    t_rx;
    end_sim;
  end
endmodule
bind dual_serial_port_uart serial_asserts #(
  .VENDOR_ID(VENDOR_ID), .DEVICE_ID(DEVICE_ID), .GATE_LEVEL(GATE_LEVEL)
) chk_i (
  .clk, .rst_n, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
  .first_serial_port_base, .second_serial_port_base,
  .vendor_id, .device_id, .first_auto_mode, .second_auto_mode,
  .first_tx, .first_rts, .first_drv_en, .first_irq,
  .second_rts, .second_drv_en
);
